// ### design/hmf_device.sv
`timescale 1ns/10ps
module hmf_device #(
	parameter int unsigned P_BIT_CYCLES = hmf_pkg::BIT_CYCLES_DFLT
) (
	input wire logic i_mclk,
	input wire logic i_rst_b,
	hmf_link_if.dev link,
	input wire logic i_sample_valid,
	input wire logic i_flush_en,
	input wire logic [4:0] i_tap_sel,
	output logic o_use_gyro,
	output logic o_fir_enable,
	output logic o_reading_strobe,
	output logic [63:0] o_tap_coeff,
	output logic [5:0] o_tap_count,
	output logic [7:0] o_mode,
	output logic [7:0] o_nv_mode,
	output logic o_accel_restore,
	output logic o_sensor_pwr,
	output logic o_cpu_pwr,
	output logic o_line_drv_en
);
	import hmf_pkg::*;
	typedef struct packed {
		hmf_rx_t rx_st;
		logic [15:0] rx_len;
		logic [15:0] rx_idx;
		logic [15:0] rx_crc;
		logic [7:0] rx_id;
		logic [7:0] rx_p0;
		logic [7:0] rx_p1;
		logic [7:0] rx_p2;
		logic [31:0][63:0] stage;
		logic [31:0][63:0] taps;
		logic [5:0] tap_count;
		logic [5:0] fill;
		logic [7:0] mode;
		logic [7:0] nv_mode;
		hmf_tx_t tx_st;
		logic [7:0] tx_id;
		logic [15:0] tx_len;
		logic [15:0] tx_idx;
		logic [15:0] tx_crc;
		logic tx_valid;
		logic [7:0] tx_byte;
		hmf_pwr_t pwr;
		logic wake_pend;
		logic discard;
		logic use_gyro;
		logic fir_enable;
		logic reading_strobe;
		logic [63:0] tap_coeff;
		logic accel_restore;
		logic sensor_pwr;
		logic cpu_pwr;
		logic line_drv_en;
	} hmf_dev_state_t;
	hmf_dev_state_t q;
	hmf_dev_state_t d;
	logic u_tx_ready;
	logic u_rx_valid;
	logic [7:0] u_rx_byte;
	logic u_rx_active;
	logic rx_take;
	logic frame_ok;
	logic [15:0] crc_n;
	logic [15:0] plen;
	logic [15:0] k;
	logic [15:0] tk;
	logic [7:0] tx_b;
	logic [5:0] fill_n;

	hmf_uart #(.P_BIT_CYCLES(P_BIT_CYCLES)) u_uart (
		.i_mclk(i_mclk),
		.i_rst_b(i_rst_b),
		.i_rx(link.host_tx),
		.o_tx(link.dev_tx),
		.i_tx_valid(q.tx_valid),
		.i_tx_data(q.tx_byte),
		.o_tx_ready(u_tx_ready),
		.o_rx_valid(u_rx_valid),
		.o_rx_data(u_rx_byte),
		.o_rx_active(u_rx_active)
	);

	always_comb
	begin
		d = q;
		d.accel_restore = 1'b0;
		d.reading_strobe = 1'b0;
		rx_take = u_rx_valid && (q.pwr == PWR_ON) && !q.discard;
		if (u_rx_valid && q.discard)
			d.discard = 1'b0;
		crc_n = hmf_crc_step(q.rx_crc, u_rx_byte);
		frame_ok = 1'b0;
		k = q.rx_idx - 16'h0006;
		plen = q.rx_len - FRAME_OVERHEAD;
		if (rx_take)
		begin
			d.rx_crc = crc_n;
			d.rx_idx = q.rx_idx + 16'h0001;
			case (q.rx_st)
				RX_LEN_HI:
				begin
					d.rx_len = {u_rx_byte, 8'h00};
					d.rx_crc = hmf_crc_step(16'h0000, u_rx_byte);
					d.rx_idx = 16'h0001;
					d.rx_st = RX_LEN_LO;
				end
				RX_LEN_LO:
				begin
					d.rx_len = {q.rx_len[15:8], u_rx_byte};
					d.rx_st = RX_BODY;
					if (d.rx_len < FRAME_OVERHEAD || d.rx_len > FRAME_MAX_LEN)
						d.rx_st = RX_LEN_HI;
				end
				RX_BODY:
				begin
					if (q.rx_idx == 16'h0002)
						d.rx_id = u_rx_byte;
					if (q.rx_idx == 16'h0003)
						d.rx_p0 = u_rx_byte;
					if (q.rx_idx == 16'h0004)
						d.rx_p1 = u_rx_byte;
					if (q.rx_idx == 16'h0005)
						d.rx_p2 = u_rx_byte;
					if (q.rx_idx >= 16'h0006 && k < 16'h0100)
						d.stage[k[7:3]][{~k[2:0], 3'b000} +: 8] = u_rx_byte;
					if (q.rx_idx == q.rx_len - 16'h0001)
					begin
						d.rx_st = RX_LEN_HI;
						frame_ok = (crc_n == 16'h0000);
					end
				end
				default:
					d.rx_st = RX_LEN_HI;
			endcase
		end
		if (q.wake_pend && q.tx_st == TX_IDLE && q.pwr == PWR_ON)
		begin
			d.wake_pend = 1'b0;
			d.tx_st = TX_SEND;
			d.tx_id = ID_WAKE_CONFIRM;
			d.tx_len = FRAME_OVERHEAD;
			d.tx_idx = 16'h0000;
			d.tx_crc = 16'h0000;
		end
		else if (frame_ok && q.tx_st == TX_IDLE)
		begin
			d.tx_idx = 16'h0000;
			d.tx_crc = 16'h0000;
			d.tx_len = FRAME_OVERHEAD;
			d.tx_id = 8'h00;
			case (q.rx_id)
				ID_SET_MODE:
					if (plen == 16'h0001 && q.rx_p0 <= MODE_FUSED)
						d.mode = q.rx_p0;
				ID_PERSIST:
					d.nv_mode = q.mode;
				ID_QUERY_MODE:
					if (plen == 16'h0000)
					begin
						d.tx_id = ID_MODE_REPLY;
						d.tx_len = FRAME_OVERHEAD + 16'h0001;
					end
				ID_SET_FILTER:
					if (q.rx_p0 == FILT_SEL_A && q.rx_p1 == FILT_SEL_B && hmf_tap_count_ok(q.rx_p2)
						&& q.rx_len == hmf_filter_len(q.rx_p2))
					begin
						d.taps = q.stage;
						d.tap_count = q.rx_p2[5:0];
						d.fill = 6'h00;
						d.tx_id = ID_FILTER_ACK;
					end
				ID_QUERY_FILTER:
					if (plen == 16'h0002 && q.rx_p0 == FILT_SEL_A && q.rx_p1 == FILT_SEL_B)
					begin
						d.tx_id = ID_FILTER_REPLY;
						d.tx_len = hmf_filter_len({2'b00, q.tap_count});
					end
				ID_SLEEP:
					if (plen == 16'h0000 && q.mode == MODE_COMPASS)
					begin
						d.tx_id = ID_SLEEP_ACK;
						d.pwr = PWR_DRAIN;
					end
				ID_ACCEL_RESTORE:
					if (plen == 16'h0000)
					begin
						d.accel_restore = 1'b1;
						d.tx_id = ID_ACCEL_DONE;
					end
				default:
					d.tx_id = 8'h00;
			endcase
			if (d.tx_id != 8'h00)
				d.tx_st = TX_SEND;
		end
		tk = q.tx_idx - 16'h0006;
		case (q.tx_idx)
			16'h0000: tx_b = q.tx_len[15:8];
			16'h0001: tx_b = q.tx_len[7:0];
			16'h0002: tx_b = q.tx_id;
			16'h0003: tx_b = (q.tx_id == ID_MODE_REPLY) ? q.mode : FILT_SEL_A;
			16'h0004: tx_b = FILT_SEL_B;
			16'h0005: tx_b = {2'b00, q.tap_count};
			default: tx_b = q.taps[tk[7:3]][{~tk[2:0], 3'b000} +: 8];
		endcase
		if (q.tx_idx == q.tx_len - 16'h0002)
			tx_b = q.tx_crc[15:8];
		else if (q.tx_idx == q.tx_len - 16'h0001)
			tx_b = q.tx_crc[7:0];
		case (q.tx_st)
			TX_SEND:
				if (!q.tx_valid)
				begin
					d.tx_valid = 1'b1;
					d.tx_byte = tx_b;
				end
				else if (u_tx_ready)
				begin
					d.tx_valid = 1'b0;
					if (q.tx_idx < q.tx_len - 16'h0002)
						d.tx_crc = hmf_crc_step(q.tx_crc, q.tx_byte);
					d.tx_idx = q.tx_idx + 16'h0001;
					if (q.tx_idx == q.tx_len - 16'h0001)
						d.tx_st = TX_IDLE;
				end
			default:
				d.tx_valid = 1'b0;
		endcase
		case (q.pwr)
			PWR_DRAIN:
				if (q.tx_st == TX_IDLE && u_tx_ready)
				begin
					d.pwr = PWR_SLEEP;
					d.sensor_pwr = 1'b0;
					d.cpu_pwr = 1'b0;
					d.line_drv_en = 1'b0;
				end
			PWR_SLEEP:
				if (u_rx_active)
				begin
					d.pwr = PWR_ON;
					d.sensor_pwr = 1'b1;
					d.cpu_pwr = 1'b1;
					d.line_drv_en = 1'b1;
					d.discard = 1'b1;
					d.wake_pend = 1'b1;
					d.rx_st = RX_LEN_HI;
				end
			default:
				if (q.pwr != PWR_ON)
					d.pwr = PWR_ON;
		endcase
		fill_n = (q.fill == q.tap_count) ? q.fill : q.fill + 6'h01;
		if (q.mode != MODE_COMPASS || q.tap_count == 6'h00)
			d.fill = 6'h00;
		if (i_sample_valid && q.pwr == PWR_ON)
		begin
			if (q.mode != MODE_COMPASS || q.tap_count == 6'h00)
				d.reading_strobe = 1'b1;
			else if (fill_n == q.tap_count)
			begin
				d.reading_strobe = 1'b1;
				d.fill = i_flush_en ? 6'h00 : fill_n;
			end
			else
				d.fill = fill_n;
		end
		d.use_gyro = (d.mode == MODE_FUSED);
		d.fir_enable = (d.mode == MODE_COMPASS) && (d.tap_count != 6'h00);
		d.tap_coeff = q.taps[i_tap_sel];
		if (!i_rst_b)
		begin
			d = '0;
			d.mode = MODE_RESET;
			d.nv_mode = MODE_RESET;
			d.use_gyro = 1'b1;
			d.sensor_pwr = 1'b1;
			d.cpu_pwr = 1'b1;
			d.line_drv_en = 1'b1;
		end
	end

	always_ff @(posedge i_mclk)
		q <= d;

	assign o_use_gyro = q.use_gyro;
	assign o_fir_enable = q.fir_enable;
	assign o_reading_strobe = q.reading_strobe;
	assign o_tap_coeff = q.tap_coeff;
	assign o_tap_count = q.tap_count;
	assign o_mode = q.mode;
	assign o_nv_mode = q.nv_mode;
	assign o_accel_restore = q.accel_restore;
	assign o_sensor_pwr = q.sensor_pwr;
	assign o_cpu_pwr = q.cpu_pwr;
	assign o_line_drv_en = q.line_drv_en;
endmodule : hmf_device

// ### shared/hmf_pkg.sv
// Function
// - accel factory restore answered by frame 37
// - compass mode excludes gyro, fused uses all
// - mode id 79, 0 compass, 1 fused default
// - mode volatile until persist command stores it; here reset loads fused into both mode and nv_mode
// - mode query 80 answered by 81 with mode
// - host selects compass before any calibration
// - sleep only allowed while in compass mode
// - smoothing filter acts only in compass mode
// - no filtered output until all taps refilled
// - flush clears taps after each reading
// - filter set id 12, bytes 3 then 1
// - tap count 0,4,8,16,32 then float64 taps
// - host loads recommended symmetric taps for 4-tap set only, others from i_taps
// - filter set acknowledged by frame 20
// - filter query 13 answered by 14
// - sleep command 15 powers sensors, cpu, driver off
// - receive line stays alive, activity wakes device
// - sleep command acknowledged by frame 28
// - after wake send confirmation frame 23
// - host requests sleep only in compass mode
package hmf_pkg;
	localparam int unsigned CLK_HZ = 200_000_000;
	localparam int unsigned BAUD_RATE = 38400;
	localparam int unsigned BIT_CYCLES_DFLT = CLK_HZ / BAUD_RATE;
	localparam logic [7:0] ID_SET_MODE = 8'h4f;
	localparam logic [7:0] ID_QUERY_MODE = 8'h50;
	localparam logic [7:0] ID_MODE_REPLY = 8'h51;
	localparam logic [7:0] ID_SET_FILTER = 8'h0c;
	localparam logic [7:0] ID_FILTER_ACK = 8'h14;
	localparam logic [7:0] ID_QUERY_FILTER = 8'h0d;
	localparam logic [7:0] ID_FILTER_REPLY = 8'h0e;
	localparam logic [7:0] ID_SLEEP = 8'h0f;
	localparam logic [7:0] ID_SLEEP_ACK = 8'h1c;
	localparam logic [7:0] ID_WAKE_CONFIRM = 8'h17;
	localparam logic [7:0] ID_ACCEL_RESTORE = 8'h24;
	localparam logic [7:0] ID_ACCEL_DONE = 8'h25;
	localparam logic [7:0] ID_PERSIST = 8'h09;
	localparam logic [7:0] MODE_COMPASS = 8'h00;
	localparam logic [7:0] MODE_FUSED = 8'h01;
	localparam logic [7:0] MODE_RESET = MODE_FUSED;
	localparam logic [7:0] FILT_SEL_A = 8'h03;
	localparam logic [7:0] FILT_SEL_B = 8'h01;
	localparam logic [7:0] WAKE_BYTE = 8'h00;
	localparam logic [15:0] FRAME_OVERHEAD = 16'h0005;
	localparam logic [15:0] FRAME_MAX_LEN = 16'h0108;
	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam logic [63:0] TAP4_OUTER = $realtobits(4.6708657655334e-2);
	localparam logic [63:0] TAP4_INNER = $realtobits(4.5329134234467e-1);

	typedef enum logic [1:0] {U_IDLE, U_START, U_DATA, U_STOP} hmf_uart_t;
	typedef enum logic [1:0] {RX_LEN_HI, RX_LEN_LO, RX_BODY} hmf_rx_t;
	typedef enum logic {TX_IDLE, TX_SEND} hmf_tx_t;
	typedef enum logic [1:0] {PWR_ON, PWR_DRAIN, PWR_SLEEP} hmf_pwr_t;
	typedef enum logic [2:0] {REQ_SET_MODE, REQ_QUERY_MODE, REQ_SET_FILTER, REQ_QUERY_FILTER,
		REQ_SLEEP, REQ_SAVE, REQ_ACCEL_RESTORE, REQ_WAKE} hmf_req_t;

	function automatic logic [15:0] hmf_crc_step(input logic [15:0] crc, input logic [7:0] b);
		logic [15:0] c;
		c = crc ^ {b, 8'h00};
		for (int i = 0; i < 8; i++)
			c = c[15] ? ({c[14:0], 1'b0} ^ CRC_POLY) : {c[14:0], 1'b0};
		return c;
	endfunction : hmf_crc_step

	function automatic logic hmf_tap_count_ok(input logic [7:0] c);
		return (c == 8'h00) || (c == 8'h04) || (c == 8'h08) || (c == 8'h10) || (c == 8'h20);
	endfunction : hmf_tap_count_ok

	function automatic logic [15:0] hmf_filter_len(input logic [7:0] c);
		return FRAME_OVERHEAD + 16'h0003 + {5'h00, c, 3'b000};
	endfunction : hmf_filter_len
endpackage : hmf_pkg

// ### shared/hmf_link_if.sv
`timescale 1ns/10ps
interface hmf_link_if;
	logic host_tx;
	logic dev_tx;
	modport dev (input host_tx, output dev_tx);
	modport host (output host_tx, input dev_tx);
endinterface : hmf_link_if

// ### design/hmf_uart.sv
`timescale 1ns/10ps
module hmf_uart #(
	parameter int unsigned P_BIT_CYCLES = hmf_pkg::BIT_CYCLES_DFLT
) (
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire logic i_rx,
	output logic o_tx,
	input wire logic i_tx_valid,
	input wire logic [7:0] i_tx_data,
	output logic o_tx_ready,
	output logic o_rx_valid,
	output logic [7:0] o_rx_data,
	output logic o_rx_active
);
	import hmf_pkg::*;
	typedef struct packed {
		logic [2:0] sync;
		logic rx_lvl;
		hmf_uart_t rx_st;
		logic [15:0] rx_cnt;
		logic [2:0] rx_bit;
		logic [7:0] rx_sh;
		logic rx_valid;
		hmf_uart_t tx_st;
		logic [15:0] tx_cnt;
		logic [3:0] tx_bit;
		logic [9:0] tx_sh;
		logic tx;
	} hmf_uart_state_t;
	localparam logic [15:0] BIT_LAST = 16'(P_BIT_CYCLES - 1);
	localparam logic [15:0] HALF_LAST = 16'(P_BIT_CYCLES / 2 - 1);
	hmf_uart_state_t q;
	hmf_uart_state_t d;

	always_comb
	begin
		d = q;
		d.rx_valid = 1'b0;
		d.sync = {q.sync[1:0], i_rx};
		if (q.sync[1] == q.sync[2])
			d.rx_lvl = q.sync[2];
		case (q.rx_st)
			U_IDLE:
				if (!q.rx_lvl)
				begin
					d.rx_st = U_START;
					d.rx_cnt = HALF_LAST;
				end
			U_START:
				if (q.rx_cnt != 16'h0000)
					d.rx_cnt = q.rx_cnt - 16'h0001;
				else if (q.rx_lvl)
					d.rx_st = U_IDLE;
				else
				begin
					d.rx_st = U_DATA;
					d.rx_cnt = BIT_LAST;
					d.rx_bit = 3'h0;
				end
			U_DATA:
				if (q.rx_cnt != 16'h0000)
					d.rx_cnt = q.rx_cnt - 16'h0001;
				else
				begin
					d.rx_sh = {q.rx_lvl, q.rx_sh[7:1]};
					d.rx_bit = q.rx_bit + 3'h1;
					d.rx_cnt = BIT_LAST;
					if (q.rx_bit == 3'h7)
						d.rx_st = U_STOP;
				end
			U_STOP:
				if (q.rx_cnt != 16'h0000)
					d.rx_cnt = q.rx_cnt - 16'h0001;
				else
				begin
					d.rx_valid = q.rx_lvl;
					d.rx_st = U_IDLE;
				end
			default:
				d.rx_st = U_IDLE;
		endcase
		case (q.tx_st)
			U_IDLE:
				if (i_tx_valid)
				begin
					d.tx_sh = {1'b1, i_tx_data, 1'b0};
					d.tx_cnt = BIT_LAST;
					d.tx_bit = 4'h0;
					d.tx_st = U_DATA;
				end
			U_DATA:
				if (q.tx_cnt != 16'h0000)
					d.tx_cnt = q.tx_cnt - 16'h0001;
				else if (q.tx_bit == 4'h9)
					d.tx_st = U_IDLE;
				else
				begin
					d.tx_sh = {1'b1, q.tx_sh[9:1]};
					d.tx_bit = q.tx_bit + 4'h1;
					d.tx_cnt = BIT_LAST;
				end
			default:
				d.tx_st = U_IDLE;
		endcase
		d.tx = (d.tx_st == U_IDLE) ? 1'b1 : d.tx_sh[0];
		if (!i_rst_b)
		begin
			d = '0;
			d.sync = 3'h7;
			d.rx_lvl = 1'b1;
			d.tx = 1'b1;
		end
	end

	always_ff @(posedge i_mclk)
		q <= d;

	assign o_tx = q.tx;
	assign o_tx_ready = (q.tx_st == U_IDLE);
	assign o_rx_valid = q.rx_valid;
	assign o_rx_data = q.rx_sh;
	assign o_rx_active = ~q.rx_lvl;
endmodule : hmf_uart

// ### design/hmf_host.sv
`timescale 1ns/10ps
module hmf_host #(
	parameter int unsigned P_BIT_CYCLES = hmf_pkg::BIT_CYCLES_DFLT
) (
	input wire logic i_mclk,
	input wire logic i_rst_b,
	hmf_link_if.host link,
	input wire logic i_req_valid,
	input wire hmf_pkg::hmf_req_t i_req_kind,
	input wire logic [7:0] i_req_arg,
	input wire logic [31:0][63:0] i_taps,
	output logic o_req_ready,
	output logic o_req_refused,
	output logic o_rsp_valid,
	output logic [7:0] o_rsp_id,
	output logic [7:0] o_rsp_byte0,
	output logic [7:0] o_rsp_byte2,
	output logic o_mode_compass
);
	import hmf_pkg::*;
	typedef struct packed {
		hmf_rx_t rx_st;
		logic [15:0] rx_len;
		logic [15:0] rx_idx;
		logic [15:0] rx_crc;
		logic [7:0] rx_id;
		logic [7:0] rx_p0;
		logic [7:0] rx_p2;
		hmf_tx_t tx_st;
		logic raw;
		logic [7:0] tx_id;
		logic [7:0] arg;
		logic [31:0][63:0] taps;
		logic [15:0] tx_len;
		logic [15:0] tx_idx;
		logic [15:0] tx_crc;
		logic tx_valid;
		logic [7:0] tx_byte;
		logic [7:0] mode;
		logic req_ready;
		logic req_refused;
		logic rsp_valid;
		logic [7:0] rsp_id;
		logic [7:0] rsp_byte0;
		logic [7:0] rsp_byte2;
		logic mode_compass;
	} hmf_host_state_t;
	hmf_host_state_t q;
	hmf_host_state_t d;
	logic u_tx_ready;
	logic u_rx_valid;
	logic [7:0] u_rx_byte;
	logic go;
	logic [15:0] crc_n;
	logic [15:0] tk;
	logic [7:0] tx_b;

	hmf_uart #(.P_BIT_CYCLES(P_BIT_CYCLES)) u_uart (
		.i_mclk(i_mclk),
		.i_rst_b(i_rst_b),
		.i_rx(link.dev_tx),
		.o_tx(link.host_tx),
		.i_tx_valid(q.tx_valid),
		.i_tx_data(q.tx_byte),
		.o_tx_ready(u_tx_ready),
		.o_rx_valid(u_rx_valid),
		.o_rx_data(u_rx_byte),
		.o_rx_active()
	);

	always_comb
	begin
		d = q;
		d.req_refused = 1'b0;
		d.rsp_valid = 1'b0;
		go = 1'b1;
		if (i_req_valid && q.req_ready)
		begin
			d.tx_idx = 16'h0000;
			d.tx_crc = 16'h0000;
			d.raw = 1'b0;
			d.arg = i_req_arg;
			d.tx_len = FRAME_OVERHEAD;
			d.tx_id = 8'h00;
			case (i_req_kind)
				REQ_SET_MODE:
				begin
					go = (i_req_arg <= MODE_FUSED);
					d.tx_id = ID_SET_MODE;
					d.tx_len = FRAME_OVERHEAD + 16'h0001;
					if (go)
						d.mode = i_req_arg;
				end
				REQ_QUERY_MODE: d.tx_id = ID_QUERY_MODE;
				REQ_SET_FILTER:
				begin
					go = hmf_tap_count_ok(i_req_arg);
					d.tx_id = ID_SET_FILTER;
					d.tx_len = hmf_filter_len(i_req_arg);
					for (int i = 0; i < 32; i++)
						d.taps[i] = (i_req_arg == 8'h04 && i < 4) ? ((i == 0 || i == 3) ? TAP4_OUTER : TAP4_INNER)
							: i_taps[i];
				end
				REQ_QUERY_FILTER:
				begin
					d.tx_id = ID_QUERY_FILTER;
					d.tx_len = FRAME_OVERHEAD + 16'h0002;
				end
				REQ_SLEEP:
				begin
					go = (q.mode == MODE_COMPASS);
					d.tx_id = ID_SLEEP;
				end
				REQ_SAVE: d.tx_id = ID_PERSIST;
				REQ_ACCEL_RESTORE: d.tx_id = ID_ACCEL_RESTORE;
				REQ_WAKE:
				begin
					d.raw = 1'b1;
					d.tx_len = 16'h0001;
				end
				default: go = 1'b0;
			endcase
			if (go)
				d.tx_st = TX_SEND;
			else
				d.req_refused = 1'b1;
		end
		tk = q.tx_idx - 16'h0006;
		case (q.tx_idx)
			16'h0000: tx_b = q.tx_len[15:8];
			16'h0001: tx_b = q.tx_len[7:0];
			16'h0002: tx_b = q.tx_id;
			16'h0003: tx_b = (q.tx_id == ID_SET_MODE) ? q.arg : FILT_SEL_A;
			16'h0004: tx_b = FILT_SEL_B;
			16'h0005: tx_b = q.arg;
			default: tx_b = q.taps[tk[7:3]][{~tk[2:0], 3'b000} +: 8];
		endcase
		if (q.tx_idx == q.tx_len - 16'h0002)
			tx_b = q.tx_crc[15:8];
		else if (q.tx_idx == q.tx_len - 16'h0001)
			tx_b = q.tx_crc[7:0];
		if (q.raw)
			tx_b = WAKE_BYTE;
		case (q.tx_st)
			TX_SEND:
				if (!q.tx_valid)
				begin
					d.tx_valid = 1'b1;
					d.tx_byte = tx_b;
				end
				else if (u_tx_ready)
				begin
					d.tx_valid = 1'b0;
					if (q.tx_idx < q.tx_len - 16'h0002)
						d.tx_crc = hmf_crc_step(q.tx_crc, q.tx_byte);
					d.tx_idx = q.tx_idx + 16'h0001;
					if (q.tx_idx == q.tx_len - 16'h0001)
						d.tx_st = TX_IDLE;
				end
			default:
				d.tx_valid = 1'b0;
		endcase
		crc_n = hmf_crc_step(q.rx_crc, u_rx_byte);
		if (u_rx_valid)
		begin
			d.rx_crc = crc_n;
			d.rx_idx = q.rx_idx + 16'h0001;
			case (q.rx_st)
				RX_LEN_HI:
				begin
					d.rx_len = {u_rx_byte, 8'h00};
					d.rx_crc = hmf_crc_step(16'h0000, u_rx_byte);
					d.rx_idx = 16'h0001;
					d.rx_st = RX_LEN_LO;
				end
				RX_LEN_LO:
				begin
					d.rx_len = {q.rx_len[15:8], u_rx_byte};
					d.rx_st = (d.rx_len < FRAME_OVERHEAD || d.rx_len > FRAME_MAX_LEN) ? RX_LEN_HI : RX_BODY;
				end
				RX_BODY:
				begin
					if (q.rx_idx == 16'h0002)
						d.rx_id = u_rx_byte;
					if (q.rx_idx == 16'h0003)
						d.rx_p0 = u_rx_byte;
					if (q.rx_idx == 16'h0005)
						d.rx_p2 = u_rx_byte;
					if (q.rx_idx == q.rx_len - 16'h0001)
					begin
						d.rx_st = RX_LEN_HI;
						if (crc_n == 16'h0000)
						begin
							d.rsp_valid = 1'b1;
							d.rsp_id = q.rx_id;
							d.rsp_byte0 = q.rx_p0;
							d.rsp_byte2 = q.rx_p2;
							if (q.rx_id == ID_MODE_REPLY && q.rx_p0 <= MODE_FUSED)
								d.mode = q.rx_p0;
						end
					end
				end
				default:
					d.rx_st = RX_LEN_HI;
			endcase
		end
		d.req_ready = (d.tx_st == TX_IDLE) && !(i_req_valid && q.req_ready);
		d.mode_compass = (d.mode == MODE_COMPASS);
		if (!i_rst_b)
		begin
			d = '0;
			d.mode = MODE_RESET;
		end
	end

	always_ff @(posedge i_mclk)
		q <= d;

	assign o_req_ready = q.req_ready;
	assign o_req_refused = q.req_refused;
	assign o_rsp_valid = q.rsp_valid;
	assign o_rsp_id = q.rsp_id;
	assign o_rsp_byte0 = q.rsp_byte0;
	assign o_rsp_byte2 = q.rsp_byte2;
	assign o_mode_compass = q.mode_compass;
endmodule : hmf_host

// ### sim/hmf_chk.sv
`timescale 1ns/10ps
module hmf_chk
	import hmf_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire logic dev_tx,
	input wire logic i_sample_valid,
	input wire logic i_flush_en,
	input wire logic o_use_gyro,
	input wire logic o_fir_enable,
	input wire logic o_reading_strobe,
	input wire logic [5:0] o_tap_count,
	input wire logic [7:0] o_mode,
	input wire logic [7:0] o_nv_mode,
	input wire logic o_sensor_pwr,
	input wire logic o_cpu_pwr,
	input wire logic o_line_drv_en
);
	logic [5:0] fill_reg;
	logic [5:0] fill_next;
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_rst_b);
	// samples gathered since the last reading strobe or since the filter was last disabled
	always_comb
	begin
		fill_next = fill_reg + {5'h00, i_sample_valid};
		if (!o_fir_enable || o_reading_strobe)
			fill_next = {5'h00, i_sample_valid};
	end
	always_ff @(posedge i_mclk)
		fill_reg <= i_rst_b ? fill_next : 6'h00;
	sequence s_compass_held;
		(o_mode == MODE_COMPASS) [*2];
	endsequence
	sequence s_fused_held;
		(o_mode == MODE_FUSED) [*2];
	endsequence
	a_gyro_off_compass: assert property (s_compass_held |-> !o_use_gyro)
		else $error("gyro in use in compass mode");
	a_gyro_on_fused: assert property (s_fused_held |-> o_use_gyro)
		else $error("gyro unused in fused mode");
	a_fir_off_fused: assert property (s_fused_held |-> !o_fir_enable)
		else $error("filter active in fused mode");
	a_sleep_needs_compass: assert property ($fell(o_sensor_pwr) |-> o_mode == MODE_COMPASS)
		else $error("sleep entered outside compass mode");
	a_power_rails_tied: assert property (o_sensor_pwr == o_cpu_pwr && o_cpu_pwr == o_line_drv_en)
		else $error("power outputs disagree");
	a_quiet_asleep: assert property (!o_sensor_pwr |-> dev_tx && !o_reading_strobe)
		else $error("activity while asleep");
	a_fill_before_out: assert property (o_reading_strobe && o_fir_enable && i_flush_en
		|-> fill_reg == o_tap_count)
		else $error("reading before filter refilled");
	a_nv_from_mode: assert property ($changed(o_nv_mode) |-> o_nv_mode == $past(o_mode))
		else $error("stored mode differs from mode");
endmodule : hmf_chk

// ### sim/hmf_tb_top.sv
`timescale 1ns/10ps
module hmf_tb_top;
	import hmf_pkg::*;
	localparam int unsigned P_BIT = 8;
	typedef struct packed {hmf_req_t k; logic [7:0] a; logic [7:0] id; logic [7:0] b0; logic [7:0] b2;} hmf_row_t;
	logic i_mclk = 1'b0;
	logic i_rst_b = 1'b0;
	logic i_sample_valid = 1'b0;
	logic i_flush_en = 1'b0;
	logic i_req_valid = 1'b0;
	logic [4:0] i_tap_sel = 5'h00;
	hmf_req_t i_req_kind = REQ_QUERY_MODE;
	logic [7:0] i_req_arg = 8'h00;
	logic [31:0][63:0] i_taps;
	logic o_use_gyro, o_fir_enable, o_reading_strobe, o_accel_restore, o_sensor_pwr, o_cpu_pwr, o_line_drv_en;
	logic [63:0] o_tap_coeff;
	logic [5:0] o_tap_count;
	logic [7:0] o_mode, o_nv_mode, o_rsp_id, o_rsp_byte0, o_rsp_byte2;
	logic o_req_ready, o_req_refused, o_rsp_valid, o_mode_compass;
	int err_total = 0;
	int check_count = 0;
	int restores = 0;
	hmf_link_if link ();
	hmf_device #(.P_BIT_CYCLES(P_BIT)) u_hmf_device (.i_mclk, .i_rst_b, .link(link.dev), .i_sample_valid, .i_flush_en,
		.i_tap_sel, .o_use_gyro, .o_fir_enable, .o_reading_strobe, .o_tap_coeff, .o_tap_count, .o_mode, .o_nv_mode,
		.o_accel_restore, .o_sensor_pwr, .o_cpu_pwr, .o_line_drv_en);
	hmf_host #(.P_BIT_CYCLES(P_BIT)) u_hmf_host (.i_mclk, .i_rst_b, .link(link.host), .i_req_valid, .i_req_kind,
		.i_req_arg, .i_taps, .o_req_ready, .o_req_refused, .o_rsp_valid, .o_rsp_id, .o_rsp_byte0, .o_rsp_byte2,
		.o_mode_compass);
	hmf_chk u_hmf_chk (.i_mclk, .i_rst_b, .dev_tx(link.dev_tx), .i_sample_valid, .i_flush_en, .o_use_gyro,
		.o_fir_enable, .o_reading_strobe, .o_tap_count, .o_mode, .o_nv_mode, .o_sensor_pwr, .o_cpu_pwr, .o_line_drv_en);
	initial
	begin
		forever #2.5 i_mclk = ~i_mclk;
	end
	always @(negedge i_mclk)
		if (o_accel_restore === 1'b1)
			restores++;
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		check_count++;
		if (got !== exp)
		begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic done(input string s);
		$display("test %s done, mismatches %0d", s, err_total);
	endtask : done
	// one host request; id 0 means no reply is due
	task automatic req(input hmf_req_t k, input logic [7:0] a, input logic [7:0] id, output logic rf);
		int n;
		n = 0;
		while (o_req_ready !== 1'b1 && n < 40000)
		begin
			@(negedge i_mclk);
			n++;
		end
		i_req_kind = k;
		i_req_arg = a;
		i_req_valid = 1'b1;
		@(negedge i_mclk);
		i_req_valid = 1'b0;
		rf = o_req_refused;
		n = 0;
		while (id != 8'h00 && o_rsp_valid !== 1'b1 && n < 40000)
		begin
			@(negedge i_mclk);
			n++;
		end
		if (id != 8'h00)
		begin
			chk(64'(o_rsp_valid), 64'h1);
			chk(64'(o_rsp_id), 64'(id));
		end
		else
		begin
			n = 0;
			while (o_req_ready !== 1'b1 && n < 40000)
			begin
				@(negedge i_mclk);
				n++;
			end
			chk(64'(o_req_ready), 64'h1);
			repeat (24 * P_BIT) @(negedge i_mclk);
		end
	endtask : req
	// per: every per-th sample should give a reading
	task automatic samples(input int n, input int per);
		for (int s = 1; s <= n; s++)
		begin
			@(negedge i_mclk);
			i_sample_valid = 1'b1;
			@(negedge i_mclk);
			i_sample_valid = 1'b0;
			chk(64'(o_reading_strobe), 64'(s % per == 0));
			repeat (2) @(negedge i_mclk);
		end
	endtask : samples
	initial
	begin
		repeat (90000) @(posedge i_mclk);
		err_total++;
		wrap_up();
	end
	initial
	begin
		hmf_row_t rows [10];
		logic rf;
		rows = '{'{REQ_QUERY_MODE, 8'h00, ID_MODE_REPLY, 8'h01, 8'h00},
			'{REQ_SET_MODE, 8'h00, 8'h00, 8'h00, 8'h00}, '{REQ_QUERY_MODE, 8'h00, ID_MODE_REPLY, 8'h00, 8'h00},
			'{REQ_SET_FILTER, 8'h20, ID_FILTER_ACK, 8'h00, 8'h00}, '{REQ_SET_FILTER, 8'h10, ID_FILTER_ACK, 8'h00, 8'h00},
			'{REQ_SET_FILTER, 8'h00, ID_FILTER_ACK, 8'h00, 8'h00}, '{REQ_QUERY_FILTER, 8'h00, ID_FILTER_REPLY, 8'h03, 8'h00},
			'{REQ_SET_FILTER, 8'h08, ID_FILTER_ACK, 8'h00, 8'h00}, '{REQ_QUERY_FILTER, 8'h00, ID_FILTER_REPLY, 8'h03, 8'h08},
			'{REQ_ACCEL_RESTORE, 8'h00, ID_ACCEL_DONE, 8'h00, 8'h00}};
		foreach (i_taps[k])
			i_taps[k] = 64'h3ff0_0000_0000_0000 + 64'(k);
		repeat (6) @(negedge i_mclk);
		i_rst_b = 1'b1;
		chk(64'(o_mode), 64'(MODE_FUSED));
		chk(64'(o_use_gyro), 64'h1);
		chk(64'({link.host_tx, link.dev_tx}), 64'h3);
		done("reset");
		req(REQ_SET_FILTER, 8'h04, ID_FILTER_ACK, rf);
		chk(64'(o_fir_enable), 64'h0);
		samples(3, 1);
		req(REQ_SLEEP, 8'h00, 8'h00, rf);
		chk(64'(rf), 64'h1);
		done("fused");
		foreach (rows[r])
		begin
			req(rows[r].k, rows[r].a, rows[r].id, rf);
			if (rows[r].id == ID_MODE_REPLY || rows[r].id == ID_FILTER_REPLY)
				chk(64'(o_rsp_byte0), 64'(rows[r].b0));
			if (rows[r].id == ID_FILTER_REPLY)
				chk(64'(o_rsp_byte2), 64'(rows[r].b2));
		end
		i_tap_sel = 5'h05;
		repeat (2) @(negedge i_mclk);
		chk(o_tap_coeff, 64'h3ff0_0000_0000_0005);
		chk(64'(o_tap_count), 64'h8);
		chk(64'(restores), 64'h1);
		chk(64'(o_mode_compass), 64'h1);
		chk(64'(o_nv_mode), 64'(MODE_FUSED));
		req(REQ_SAVE, 8'h00, 8'h00, rf);
		chk(64'(o_nv_mode), 64'(MODE_COMPASS));
		done("table");
		req(REQ_SET_MODE, 8'h02, 8'h00, rf);
		chk(64'(rf), 64'h1);
		req(REQ_SET_FILTER, 8'h05, 8'h00, rf);
		chk(64'(rf), 64'h1);
		chk(64'(o_mode), 64'(MODE_COMPASS));
		done("refusals");
		req(REQ_SET_FILTER, 8'h04, ID_FILTER_ACK, rf);
		i_tap_sel = 5'h00;
		repeat (2) @(negedge i_mclk);
		chk(o_tap_coeff, TAP4_OUTER);
		i_flush_en = 1'b1;
		samples(8, 4);
		i_flush_en = 1'b0;
		samples(4, 4);
		samples(2, 1);
		done("filter");
		req(REQ_SLEEP, 8'h00, ID_SLEEP_ACK, rf);
		repeat (20 * P_BIT) @(negedge i_mclk);
		chk(64'(o_sensor_pwr), 64'h0);
		samples(1, 2);
		req(REQ_WAKE, 8'h00, ID_WAKE_CONFIRM, rf);
		chk(64'(o_sensor_pwr), 64'h1);
		done("power");
		i_rst_b = 1'b0;
		repeat (6) @(negedge i_mclk);
		i_rst_b = 1'b1;
		chk(64'(o_mode), 64'(MODE_FUSED));
		chk(64'(o_use_gyro), 64'h1);
		done("second reset");
		wrap_up();
	end
endmodule : hmf_tb_top
